//--- ppp_map.svh
`ifndef PPP_MAP_SVH
`define PPP_MAP_SVH

// Command byte encodings.
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WFUSE 8'h40
`define PPP_CMD_WLOCK 8'h20
`define PPP_CMD_WFLASH 8'h10
`define PPP_CMD_WEE 8'h11
`define PPP_CMD_RSIG 8'h08
`define PPP_CMD_RFUSE 8'h04
`define PPP_CMD_RFLASH 8'h02
`define PPP_CMD_REE 8'h03

// Action select codes {high, low}.
`define PPP_XA_ADDR 2'h0
`define PPP_XA_DATA 2'h1
`define PPP_XA_CMD 2'h2

// Entry select level required before and after the high voltage.
`define PPP_ENTRY_ZERO 4'h0
`define PPP_MIN_TOGGLES 3'h6

// Timing.
`define PPP_CLK_NS 100
`define PPP_HOLD_NS 100
`define PPP_HOLD_CYC ((`PPP_HOLD_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)
`define PPP_SETTLE_NS 50000
`define PPP_SETTLE_CYC (`PPP_SETTLE_NS / `PPP_CLK_NS)
`define PPP_ERASE_PHASE_CYC 1000

`endif

//--- ppp_pkg.sv
package ppp_pkg;

    typedef enum logic [3:0] {
        PPP_OP_NONE = 4'h0,
        PPP_OP_ERASE = 4'h1,
        PPP_OP_WFUSE = 4'h2,
        PPP_OP_WLOCK = 4'h3,
        PPP_OP_WFLASH = 4'h4,
        PPP_OP_WEE = 4'h5,
        PPP_OP_RSIG = 4'h6,
        PPP_OP_RFUSE = 4'h7,
        PPP_OP_RFLASH = 4'h8,
        PPP_OP_REE = 4'h9
    } ppp_op_t;

    typedef enum logic [2:0] {
        PPP_ST_OFF = 3'h0,
        PPP_ST_TOGGLE = 3'h1,
        PPP_ST_ARMED = 3'h3,
        PPP_ST_CHECK = 3'h2,
        PPP_ST_SETTLE = 3'h6,
        PPP_ST_PROG = 3'h7,
        PPP_ST_FAIL = 3'h5
    } ppp_entry_t;

    typedef enum logic [1:0] {
        PPP_ER_IDLE = 2'h0,
        PPP_ER_FLASH = 2'h1,
        PPP_ER_LOCK = 2'h3,
        PPP_ER_EE = 2'h2
    } ppp_erase_t;

endpackage : ppp_pkg

//--- ppp_erase_if.sv
`timescale 1ns/1ps

interface ppp_erase_if;
    logic start;
    logic preserve_ee;
    logic busy;
    logic flash_erase;
    logic ee_erase;
    logic lock_clear;

    modport ctrl (
        output start,
        output preserve_ee,
        input busy,
        input flash_erase,
        input ee_erase,
        input lock_clear
    );

    modport seq (
        input start,
        input preserve_ee,
        output busy,
        output flash_erase,
        output ee_erase,
        output lock_clear
    );
endinterface : ppp_erase_if

//--- ppp_erase_seq.sv
`timescale 1ns/1ps
`include "ppp_map.svh"

module ppp_erase_seq
    import ppp_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    ppp_erase_if.seq er
);

    ppp_erase_t state_ff;
    ppp_erase_t nxt_state_ff;
    logic [9:0] cnt_ff;
    logic [9:0] nxt_cnt_ff;
    logic busy_ff;
    logic nxt_busy_ff;
    logic flash_ff;
    logic nxt_flash_ff;
    logic ee_ff;
    logic nxt_ee_ff;
    logic lock_ff;
    logic nxt_lock_ff;

    always_comb begin
        nxt_state_ff = state_ff;
        nxt_cnt_ff = cnt_ff;
        case (state_ff)
            PPP_ER_IDLE: begin
                if (er.start) begin
                    nxt_state_ff = PPP_ER_FLASH;
                    nxt_cnt_ff = 10'(`PPP_ERASE_PHASE_CYC - 1);
                end
            end
            PPP_ER_FLASH: begin
                if (cnt_ff == 10'h000) begin
                    // Locks only drop once flash is wholly erased.
                    nxt_state_ff = PPP_ER_LOCK;
                end else begin
                    nxt_cnt_ff = cnt_ff - 10'h001;
                end
            end
            PPP_ER_LOCK: begin
                if (er.preserve_ee) begin
                    nxt_state_ff = PPP_ER_IDLE;
                end else begin
                    nxt_state_ff = PPP_ER_EE;
                    nxt_cnt_ff = 10'(`PPP_ERASE_PHASE_CYC - 1);
                end
            end
            PPP_ER_EE: begin
                if (cnt_ff == 10'h000) begin
                    nxt_state_ff = PPP_ER_IDLE;
                end else begin
                    nxt_cnt_ff = cnt_ff - 10'h001;
                end
            end
            default: begin
                nxt_state_ff = PPP_ER_IDLE;
            end
        endcase
        // Fuse bits have no path out of this sequencer at all.
        nxt_busy_ff = (nxt_state_ff != PPP_ER_IDLE);
        nxt_flash_ff = (nxt_state_ff == PPP_ER_FLASH);
        nxt_lock_ff = (nxt_state_ff == PPP_ER_LOCK);
        nxt_ee_ff = (nxt_state_ff == PPP_ER_EE);
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_ff <= PPP_ER_IDLE;
            cnt_ff <= 10'h000;
            busy_ff <= 1'b0;
            flash_ff <= 1'b0;
            ee_ff <= 1'b0;
            lock_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state_ff;
            cnt_ff <= nxt_cnt_ff;
            busy_ff <= nxt_busy_ff;
            flash_ff <= nxt_flash_ff;
            ee_ff <= nxt_ee_ff;
            lock_ff <= nxt_lock_ff;
        end
    end

    assign er.busy = busy_ff;
    assign er.flash_erase = flash_ff;
    assign er.ee_erase = ee_ff;
    assign er.lock_clear = lock_ff;

endmodule : ppp_erase_seq

//--- ppp_top.sv
`timescale 1ns/1ps
`include "ppp_map.svh"

// Summary of operation
// - Write commands: fuse 0x40, lock 0x20, flash 0x10, EEPROM 0x11.
// - Command 0x80 requests a whole chip erase.
// - Read commands: fuse and lock 0x04, flash 0x02, EEPROM 0x03.
// - Command 0x08 reads identification bytes and calibration byte.
// - Loaded command and address are kept while operations run.
// - Chip erase clears flash, EEPROM and locks, never fuses.
// - Lock bits are released only after flash erase has completed.
// - With the preserve fuse programmed, chip erase spares the EEPROM.
// - Oscillator input rising edge latches the command byte when selected.
// - Write strobe low pulse starts erase; ready/busy is low meanwhile.

module ppp_top
    import ppp_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic reset_pin_low,
    input wire logic reset_pin_hv,
    input wire logic [3:0] entry_select,
    input wire logic oscillator_input_pin,
    input wire logic action_select_high,
    input wire logic action_select_low,
    input wire logic byte_select_pin,
    input wire logic [7:0] data_bus,
    input wire logic write_strobe_n,
    input wire logic eeprom_preserve_fuse,
    output logic ready_busy_output,
    output logic prog_mode,
    output logic entry_refused,
    output logic [7:0] command_out,
    output logic [3:0] op_kind,
    output logic [15:0] address_out,
    output logic [7:0] data_out,
    output logic write_start,
    output logic read_select,
    output logic flash_erase,
    output logic eeprom_erase,
    output logic lock_clear
);

    function automatic ppp_op_t decode_cmd(input logic [7:0] cmd);
        ppp_op_t op;
        op = PPP_OP_NONE;
        case (cmd)
            `PPP_CMD_ERASE: op = PPP_OP_ERASE;
            `PPP_CMD_WFUSE: op = PPP_OP_WFUSE;
            `PPP_CMD_WLOCK: op = PPP_OP_WLOCK;
            `PPP_CMD_WFLASH: op = PPP_OP_WFLASH;
            `PPP_CMD_WEE: op = PPP_OP_WEE;
            `PPP_CMD_RSIG: op = PPP_OP_RSIG;
            `PPP_CMD_RFUSE: op = PPP_OP_RFUSE;
            `PPP_CMD_RFLASH: op = PPP_OP_RFLASH;
            `PPP_CMD_REE: op = PPP_OP_REE;
            default: op = PPP_OP_NONE;
        endcase
        return op;
    endfunction : decode_cmd

    function automatic logic is_write_op(input ppp_op_t op);
        return (op == PPP_OP_WFUSE) || (op == PPP_OP_WLOCK) ||
            (op == PPP_OP_WFLASH) || (op == PPP_OP_WEE);
    endfunction : is_write_op

    function automatic logic is_read_op(input ppp_op_t op);
        return (op == PPP_OP_RSIG) || (op == PPP_OP_RFUSE) ||
            (op == PPP_OP_RFLASH) || (op == PPP_OP_REE);
    endfunction : is_read_op

    ppp_erase_if er ();

    ppp_erase_seq u_erase (
        .clock(clock),
        .rstn(rstn),
        .er(er.seq)
    );

    // Edge detection on the sampled strobes.
    logic osc_prev_ff;
    logic wr_prev_ff;
    logic osc_rise;
    logic wr_fall;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            osc_prev_ff <= 1'b0;
            wr_prev_ff <= 1'b1;
        end else begin
            osc_prev_ff <= oscillator_input_pin;
            wr_prev_ff <= write_strobe_n;
        end
    end

    assign osc_rise = oscillator_input_pin & ~osc_prev_ff;
    assign wr_fall = ~write_strobe_n & wr_prev_ff;

    // Entry sequence.
    ppp_entry_t state_ff;
    ppp_entry_t nxt_state_ff;
    logic [2:0] toggles_ff;
    logic [2:0] nxt_toggles_ff;
    logic [9:0] cnt_ff;
    logic [9:0] nxt_cnt_ff;
    logic [3:0] sel_prev_ff;
    logic [3:0] nxt_sel_prev_ff;
    logic refused_ff;
    logic nxt_refused_ff;
    logic osc_edge;

    assign osc_edge = oscillator_input_pin ^ osc_prev_ff;

    always_comb begin
        nxt_state_ff = state_ff;
        nxt_toggles_ff = toggles_ff;
        nxt_cnt_ff = cnt_ff;
        nxt_sel_prev_ff = entry_select;
        nxt_refused_ff = refused_ff;
        case (state_ff)
            PPP_ST_OFF: begin
                nxt_toggles_ff = 3'h0;
                nxt_cnt_ff = 10'h000;
                if (reset_pin_low && !reset_pin_hv) begin
                    nxt_state_ff = PPP_ST_TOGGLE;
                    nxt_refused_ff = 1'b0;
                end
            end
            PPP_ST_TOGGLE: begin
                if (!reset_pin_low) begin
                    nxt_state_ff = PPP_ST_OFF;
                end else if (osc_edge) begin
                    // Each level change of the oscillator input counts as one toggle.
                    if (toggles_ff == `PPP_MIN_TOGGLES - 3'h1) begin
                        nxt_state_ff = PPP_ST_ARMED;
                    end
                    nxt_toggles_ff = toggles_ff + 3'h1;
                end
            end
            PPP_ST_ARMED: begin
                if (reset_pin_hv) begin
                    if (cnt_ff >= 10'(`PPP_HOLD_CYC) &&
                        entry_select == `PPP_ENTRY_ZERO) begin
                        nxt_state_ff = PPP_ST_CHECK;
                        nxt_cnt_ff = 10'h000;
                    end else begin
                        nxt_state_ff = PPP_ST_FAIL;
                        nxt_refused_ff = 1'b1;
                    end
                end else if (!reset_pin_low) begin
                    nxt_state_ff = PPP_ST_OFF;
                end else if (entry_select == `PPP_ENTRY_ZERO) begin
                    if (cnt_ff < 10'(`PPP_HOLD_CYC)) begin
                        nxt_cnt_ff = cnt_ff + 10'h001;
                    end
                end else begin
                    nxt_cnt_ff = 10'h000;
                end
            end
            PPP_ST_CHECK: begin
                if (!reset_pin_hv) begin
                    nxt_state_ff = PPP_ST_OFF;
                end else if (entry_select != sel_prev_ff ||
                    entry_select != `PPP_ENTRY_ZERO) begin
                    // Any movement inside the guard window refuses entry.
                    nxt_state_ff = PPP_ST_FAIL;
                    nxt_refused_ff = 1'b1;
                end else if (cnt_ff == 10'(`PPP_HOLD_CYC - 1)) begin
                    nxt_state_ff = PPP_ST_SETTLE;
                    nxt_cnt_ff = 10'h000;
                end else begin
                    nxt_cnt_ff = cnt_ff + 10'h001;
                end
            end
            PPP_ST_SETTLE: begin
                // Commands are not taken before the settle time, so ready stays low.
                if (!reset_pin_hv) begin
                    nxt_state_ff = PPP_ST_OFF;
                end else if (cnt_ff == 10'(`PPP_SETTLE_CYC - 1)) begin
                    nxt_state_ff = PPP_ST_PROG;
                end else begin
                    nxt_cnt_ff = cnt_ff + 10'h001;
                end
            end
            PPP_ST_PROG: begin
                // Dropping the high voltage mid erase abandons programming mode.
                if (!reset_pin_hv) begin
                    nxt_state_ff = PPP_ST_OFF;
                end
            end
            PPP_ST_FAIL: begin
                if (!reset_pin_hv) begin
                    nxt_state_ff = PPP_ST_OFF;
                end
            end
            default: begin
                nxt_state_ff = PPP_ST_OFF;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_ff <= PPP_ST_OFF;
            toggles_ff <= 3'h0;
            cnt_ff <= 10'h000;
            sel_prev_ff <= 4'h0;
            refused_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state_ff;
            toggles_ff <= nxt_toggles_ff;
            cnt_ff <= nxt_cnt_ff;
            sel_prev_ff <= nxt_sel_prev_ff;
            refused_ff <= nxt_refused_ff;
        end
    end

    // Command, address and data holding registers.
    logic in_prog;
    logic busy_now;
    logic [7:0] cmd_ff;
    logic [7:0] nxt_cmd_ff;
    ppp_op_t op_ff;
    ppp_op_t nxt_op_ff;
    logic [15:0] addr_ff;
    logic [15:0] nxt_addr_ff;
    logic [7:0] data_ff;
    logic [7:0] nxt_data_ff;
    logic erase_start_ff;
    logic nxt_erase_start_ff;
    logic write_start_ff;
    logic nxt_write_start_ff;
    logic ready_ff;
    logic nxt_ready_ff;
    logic prog_ff;
    logic read_ff;

    assign in_prog = (state_ff == PPP_ST_PROG);
    assign busy_now = erase_start_ff | er.busy;

    always_comb begin
        nxt_cmd_ff = cmd_ff;
        nxt_op_ff = op_ff;
        nxt_addr_ff = addr_ff;
        nxt_data_ff = data_ff;
        nxt_erase_start_ff = 1'b0;
        nxt_write_start_ff = 1'b0;
        // Loads during an erase are dropped rather than corrupting held state.
        if (in_prog && ready_ff && osc_rise) begin
            case ({action_select_high, action_select_low})
                `PPP_XA_CMD: begin
                    if (!byte_select_pin) begin
                        nxt_cmd_ff = data_bus;
                        nxt_op_ff = decode_cmd(data_bus);
                    end
                end
                `PPP_XA_ADDR: begin
                    if (byte_select_pin) begin
                        nxt_addr_ff = {data_bus, addr_ff[7:0]};
                    end else begin
                        nxt_addr_ff = {addr_ff[15:8], data_bus};
                    end
                end
                `PPP_XA_DATA: begin
                    nxt_data_ff = data_bus;
                end
                default: begin
                    nxt_data_ff = data_ff;
                end
            endcase
        end
        if (in_prog && ready_ff && wr_fall) begin
            nxt_erase_start_ff = (op_ff == PPP_OP_ERASE);
            nxt_write_start_ff = is_write_op(op_ff);
        end
        // Ready rises with programming mode and has no gap while the sequencer wakes up.
        nxt_ready_ff = (nxt_state_ff == PPP_ST_PROG) && !nxt_erase_start_ff &&
            !busy_now;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cmd_ff <= 8'h00;
            op_ff <= PPP_OP_NONE;
            addr_ff <= 16'h0000;
            data_ff <= 8'h00;
            erase_start_ff <= 1'b0;
            write_start_ff <= 1'b0;
            ready_ff <= 1'b0;
            prog_ff <= 1'b0;
            read_ff <= 1'b0;
        end else begin
            // Holding registers persist across operations.
            cmd_ff <= nxt_cmd_ff;
            op_ff <= nxt_op_ff;
            addr_ff <= nxt_addr_ff;
            data_ff <= nxt_data_ff;
            erase_start_ff <= nxt_erase_start_ff;
            write_start_ff <= nxt_write_start_ff;
            ready_ff <= nxt_ready_ff;
            prog_ff <= (nxt_state_ff == PPP_ST_PROG);
            read_ff <= in_prog && is_read_op(nxt_op_ff);
        end
    end

    assign er.start = erase_start_ff;
    assign er.preserve_ee = eeprom_preserve_fuse;

    assign ready_busy_output = ready_ff;
    assign prog_mode = prog_ff;
    assign entry_refused = refused_ff;
    assign command_out = cmd_ff;
    assign op_kind = op_ff;
    assign address_out = addr_ff;
    assign data_out = data_ff;
    assign write_start = write_start_ff;
    assign read_select = read_ff;
    assign flash_erase = er.flash_erase;
    assign eeprom_erase = er.ee_erase;
    assign lock_clear = er.lock_clear;

endmodule : ppp_top

//--- ppp_programmer.sv
`timescale 1ns/1ps
`include "ppp_map.svh"

// External programmer; the bench calls its tasks, which drive pins after each rising edge.
module ppp_programmer (
    input wire logic clock,
    output logic reset_pin_low,
    output logic reset_pin_hv,
    output logic [3:0] entry_select,
    output logic osc,
    output logic xa_high,
    output logic xa_low,
    output logic bs,
    output logic [7:0] data_bus,
    output logic write_strobe_n
);
    initial begin
        reset_pin_low = 1'b0;
        reset_pin_hv = 1'b0;
        entry_select = 4'hF;
        osc = 1'b0;
        {xa_high, xa_low} = 2'h3;
        bs = 1'b0;
        data_bus = 8'h00;
        write_strobe_n = 1'b1;
    end

    task automatic enter(input logic bad);
        @(posedge clock);
        reset_pin_hv <= 1'b0;
        reset_pin_low <= 1'b1;
        entry_select <= 4'hF;
        repeat (3) @(posedge clock);
        repeat (6) begin
            @(posedge clock);
            osc <= ~osc;
        end
        @(posedge clock);
        entry_select <= `PPP_ENTRY_ZERO;
        repeat (2) @(posedge clock);
        reset_pin_hv <= 1'b1;
        reset_pin_low <= 1'b0;
        @(posedge clock);
        if (bad) begin
            entry_select <= 4'h5;
        end
        // Somewhat over the settle time, so the first command is never early.
        repeat (520) @(posedge clock);
    endtask : enter

    task automatic load(input logic [1:0] xa, input logic b, input logic [7:0] d);
        @(posedge clock);
        {xa_high, xa_low} <= xa;
        bs <= b;
        data_bus <= d;
        @(posedge clock);
        osc <= 1'b1;
        @(posedge clock);
        osc <= 1'b0;
        @(posedge clock);
        // An idle bus shows the inverse, so a stale byte is never taken by luck.
        data_bus <= ~d;
    endtask : load

    task automatic strobe();
        @(posedge clock);
        write_strobe_n <= 1'b0;
        @(posedge clock);
        write_strobe_n <= 1'b1;
    endtask : strobe
endmodule : ppp_programmer

//--- ppp_top_checker.sv
`timescale 1ns/1ps
`include "ppp_map.svh"

module ppp_top_checker
    import ppp_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic oscillator_input_pin,
    input wire logic action_select_high,
    input wire logic action_select_low,
    input wire logic byte_select_pin,
    input wire logic [7:0] data_bus,
    input wire logic write_strobe_n,
    input wire logic eeprom_preserve_fuse,
    input wire logic ready_busy_output,
    input wire logic prog_mode,
    input wire logic entry_refused,
    input wire logic [7:0] command_out,
    input wire logic [3:0] op_kind,
    input wire logic write_start,
    input wire logic flash_erase,
    input wire logic eeprom_erase,
    input wire logic lock_clear
);
    logic [10:0] fe_cnt_ff;
    logic [10:0] nxt_fe_cnt;
    logic [10:0] ee_cnt_ff;
    logic [10:0] nxt_ee_cnt;
    logic go;

    always_comb begin
        nxt_fe_cnt = flash_erase ? fe_cnt_ff + 11'h001 : 11'h000;
        nxt_ee_cnt = eeprom_erase ? ee_cnt_ff + 11'h001 : 11'h000;
    end

    always_ff @(posedge clock) begin
        fe_cnt_ff <= rstn ? nxt_fe_cnt : 11'h000;
        ee_cnt_ff <= rstn ? nxt_ee_cnt : 11'h000;
    end

    assign go = prog_mode && ready_busy_output;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    ready_needs_mode_a: assert property (ready_busy_output |-> prog_mode)
        else $error("ready outside programming mode");
    refused_no_mode_a: assert property (entry_refused |-> !prog_mode)
        else $error("programming mode after a refused entry");
    erase_start_a: assert property (go && $fell(write_strobe_n) && op_kind == PPP_OP_ERASE
        |=> !ready_busy_output ##1 flash_erase) else $error("erase did not start");
    write_pulse_a: assert property (go && $fell(write_strobe_n) && op_kind inside {[2:5]}
        |=> write_start) else $error("write start missing");
    erase_decode_a: assert property ((command_out == `PPP_CMD_ERASE) == (op_kind == PPP_OP_ERASE))
        else $error("erase decode wrong");
    sig_decode_a: assert property (command_out == `PPP_CMD_RSIG |-> op_kind == PPP_OP_RSIG)
        else $error("signature read decode wrong");
    cmd_latch_a: assert property (go && $rose(oscillator_input_pin) && action_select_high
        && !action_select_low && !byte_select_pin |=> command_out == $past(data_bus))
        else $error("command byte not latched");
    cmd_kept_a: assert property (!ready_busy_output |=> $stable(command_out))
        else $error("command changed while busy");
    flash_len_a: assert property ($fell(flash_erase) |-> fe_cnt_ff == 11'h3E8)
        else $error("flash erase phase length wrong");
    lock_order_a: assert property (lock_clear |-> $past(flash_erase) && !flash_erase)
        else $error("lock clear before flash erase completed");
    ee_follow_a: assert property ($fell(lock_clear) && !eeprom_preserve_fuse |-> eeprom_erase)
        else $error("eeprom erase did not follow");
    ee_len_a: assert property ($fell(eeprom_erase) |-> ee_cnt_ff == 11'h3E8)
        else $error("eeprom erase phase length wrong");
    fuse_spare_a: assert property (eeprom_preserve_fuse |-> !eeprom_erase)
        else $error("eeprom erased with preserve fuse");
    busy_low_a: assert property (flash_erase || lock_clear || eeprom_erase |-> !ready_busy_output)
        else $error("ready high during erase");
endmodule : ppp_top_checker

bind ppp_top ppp_top_checker chk_i (.clock(clock), .rstn(rstn),
    .oscillator_input_pin(oscillator_input_pin), .action_select_high(action_select_high),
    .action_select_low(action_select_low), .byte_select_pin(byte_select_pin),
    .data_bus(data_bus), .write_strobe_n(write_strobe_n),
    .eeprom_preserve_fuse(eeprom_preserve_fuse), .ready_busy_output(ready_busy_output),
    .prog_mode(prog_mode), .entry_refused(entry_refused), .command_out(command_out),
    .op_kind(op_kind), .write_start(write_start), .flash_erase(flash_erase),
    .eeprom_erase(eeprom_erase), .lock_clear(lock_clear));

//--- ppp_top_tb.sv
`timescale 1ns/1ps

module ppp_top_tb
    import ppp_pkg::*;
;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic fuse = 1'b0;
    logic rl, hv, osc, xh, xl, bs, wr_n, rdy, pm, ref_f, ws, fe, ee, lc, rs;
    logic [3:0] es, op;
    logic [7:0] db, cmd, dout, last_cmd;
    logic [15:0] addr;
    logic [31:0] a;
    logic [11:0] cq[$];
    logic [3:0] wq[$];
    int bq[$];
    int n_fail = 0;
    int check_count = 0;
    int busy_n = 0;
    int seed = 34;
    logic [7:0] codes[9] = '{8'h40, 8'h20, 8'h10, 8'h11, 8'h08, 8'h04, 8'h02, 8'h03, 8'hFF};
    logic [3:0] ops[9] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h0};

    always #50 clock = ~clock;

    ppp_top dut (.clock(clock), .rstn(rstn), .reset_pin_low(rl), .reset_pin_hv(hv),
        .entry_select(es), .oscillator_input_pin(osc), .action_select_high(xh),
        .action_select_low(xl), .byte_select_pin(bs), .data_bus(db), .write_strobe_n(wr_n),
        .eeprom_preserve_fuse(fuse), .ready_busy_output(rdy), .prog_mode(pm),
        .entry_refused(ref_f), .command_out(cmd), .op_kind(op), .address_out(addr),
        .data_out(dout), .write_start(ws), .read_select(rs), .flash_erase(fe),
        .eeprom_erase(ee), .lock_clear(lc));

    ppp_programmer prog (.clock(clock), .reset_pin_low(rl), .reset_pin_hv(hv),
        .entry_select(es), .osc(osc), .xa_high(xh), .xa_low(xl), .bs(bs), .data_bus(db),
        .write_strobe_n(wr_n));

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    // Reads old values at the edge, so each note meets the result of the prior edge.
    always @(posedge clock) begin
        if (rstn && cmd !== last_cmd) begin
            chk("command", cq.size() ? cq[0] : 12'hFFF, {cmd, op});
            chk("read select", (cq[0][3:0] inside {[4'h6:4'h9]}), rs);
            if (cq.size()) void'(cq.pop_front());
        end
        if (rstn && ws === 1'b1) begin
            chk("write op", wq.size() ? wq[0] : 4'hF, op);
            if (wq.size()) void'(wq.pop_front());
        end
        if (pm === 1'b1 && rdy === 1'b0) begin
            busy_n++;
        end else if (busy_n > 0) begin
            chk("busy cycles", bq.size() ? bq[0] : 0, busy_n);
            if (bq.size()) void'(bq.pop_front());
            busy_n = 0;
        end
        last_cmd = cmd;
    end

    initial begin
        #2000000;
        n_fail++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        @(negedge clock);
        chk("idle outputs", 16'h0, {rdy, pm, ref_f, ws, fe, ee, lc, op});
        prog.enter(1'b1);
        @(negedge clock);
        chk("refused", 16'h1, {pm, ref_f});
        prog.enter(1'b0);
        @(negedge clock);
        chk("entered", 16'h6, {pm, rdy, ref_f});
        cq.push_back({8'h80, 4'h1});
        prog.load(2'h2, 1'b0, 8'h80);
        // The chip is erased before any flash or EEPROM write command is strobed.
        for (int f = 0; f < 2; f++) begin
            @(posedge clock);
            fuse <= f[0];
            bq.push_back(f ? 1003 : 2003);
            prog.strobe();
            prog.load(2'h2, 1'b0, 8'h02);
            repeat (3000) if (rdy !== 1'b1) @(posedge clock);
            @(negedge clock);
            chk("ready after erase", 16'h1, rdy);
            chk("command kept", 16'h80, cmd);
        end
        repeat (3) begin
            a = $random(seed);
            // Erased cells already hold 0xFF, so that data byte is never sent.
            if (a[23:16] == 8'hFF) a[23:16] = 8'h00;
            prog.load(2'h0, 1'b1, a[15:8]);
            prog.load(2'h0, 1'b0, a[7:0]);
            prog.load(2'h1, 1'b0, a[23:16]);
            @(negedge clock);
            chk("address_out", a[15:0], addr);
            chk("data_out", a[23:16], dout);
        end
        for (int i = 0; i < 9; i++) begin
            cq.push_back({codes[i], ops[i]});
            prog.load(2'h2, 1'b0, codes[i]);
            if (ops[i] inside {[2:5]}) wq.push_back(ops[i]);
            prog.strobe();
            repeat (2) @(posedge clock);
        end
        prog.load(2'h2, 1'b1, 8'h40);
        @(negedge clock);
        chk("byte select load", 16'hFF, cmd);
        repeat (3) @(posedge clock);
        chk("pending notes", 16'h0, cq.size() + wq.size() + bq.size());
        summarize();
    end
endmodule : ppp_top_tb
